// File: src/bit_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Two-stage synchronizer. It has no reset, so it can also carry a reset
// into another domain.
// ==========================================================================
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input  wire logic             clk,
  // Asynchronous level in, synchronized level out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    stage1 <= d;
    q      <= stage1;
  end

endmodule : bit_sync

`default_nettype wire

// File: src/dac_sample_formatter.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Sample formatter and link transmitter for a high-speed converter.
// ==========================================================================
// How it works
// - Dual: two 128-bit reads build one 256-bit word.
// - Converter select input chooses dual or single.
// - Only select code 11 means dual bus.
// - Dual bus reads every cycle once ready.
// - Dual: lower half A/B, upper C/D.
// - Single bus reads every other cycle.
// - Single bus mirrors data into both halves.
// - Output word valid only on alternate cycles.
// - Sixteen frame and sync bits per word.
// - Sync marks the first word of patterns.
// - Frame marks every 64 samples per bus.
// - Rewire halves so lanes leave MSB first.
// - Serialize 128-bit words onto 16 lanes.
// - Two independent paths for the two halves.
// - Upper marker bits serialized onto single lines.
// - Only one frame and sync line.
// - Data clock serialized with the A/B path.
// - Core clock is four times reference.
// - Parallel capture register, separate fast/slow clocks.
module dac_sample_formatter (
  // Clocks and reset.
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ser_clk,
  // Bridge FIFO side.
  input  wire logic         drdy,
  input  wire logic         first_data,
  input  wire logic [127:0] din,
  output logic              rdreq,
  // Configuration, gates and reference clock.
  input  wire logic [1:0]   dac_sel,
  input  wire logic         frame_en,
  input  wire logic         sync_en,
  input  wire logic         reference_clock_input,
  // Parallel output word.
  output logic      [255:0] dout,
  output logic              out_valid,
  output logic      [15:0]  frame_out,
  output logic      [15:0]  sync_out,
  output logic              ref_lock,
  // Link toward the converter.
  output logic      [15:0]  ab_lane,
  output logic      [15:0]  cd_lane,
  output logic              frame_line,
  output logic              sync_line,
  output logic              dclk_line
);

  // ========================================================================
  // Bit rewiring
  // ========================================================================

  // Sample i bit j goes to lane j, slot 7-i, so lanes emit MSB first.
  function automatic logic [127:0] rotate_half(input logic [127:0] h);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < dsf_pkg::SAMPLES_PER_HALF; i++) begin
      for (int j = 0; j < dsf_pkg::SAMPLE_W; j++) begin
        r[j*dsf_pkg::SER_RATIO + dsf_pkg::SER_RATIO - 1 - i] = h[i*dsf_pkg::SAMPLE_W + j];
      end
    end
    return r;
  endfunction : rotate_half

  // Upper marker bits onto one lane; sample 8 goes out first.
  function automatic logic [7:0] rotate_mark(input logic [15:0] m);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < dsf_pkg::SER_RATIO; i++) begin
      r[dsf_pkg::SER_RATIO - 1 - i] = m[dsf_pkg::SER_RATIO + i];
    end
    return r;
  endfunction : rotate_mark

  // ========================================================================
  // Input synchronizers
  // ========================================================================

  logic [1:0] sel_s;
  logic [1:0] gate_s;
  logic       ref_s;
  logic       ref_q;
  logic       link_rst;

  // The select is quasi-static; a momentary skew between its bits during a
  // change can misformat at most one word.
  bit_sync #(.WIDTH(2)) u_sel_sync  (.clk(mclk), .d(dac_sel), .q(sel_s));
  bit_sync #(.WIDTH(2)) u_gate_sync (.clk(mclk), .d({frame_en, sync_en}), .q(gate_s));
  bit_sync #(.WIDTH(1)) u_ref_sync  (.clk(mclk), .d(reference_clock_input), .q(ref_s));
  bit_sync #(.WIDTH(1)) u_rst_sync  (.clk(ser_clk), .d(srst), .q(link_rst));

  logic dual;
  logic fgate;
  logic sgate;

  // Anything but the dual code falls back to single-bus formatting.
  assign dual  = (sel_s == dsf_pkg::DUAL_SEL);
  assign fgate = gate_s[1];
  assign sgate = gate_s[0];

  // ========================================================================
  // Read pacing
  // ========================================================================

  logic ph;
  logic ph_d;
  logic rd_d;
  logic first_q;
  logic emit;

  // Phase alternates while the bridge is ready and restarts when it drops.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ph <= 1'b0;
    end else if (drdy) begin
      ph <= ~ph;
    end else begin
      ph <= 1'b0;
    end
  end

  // Dual reads every cycle; single reads on phase zero only. The ready flag
  // is trusted to stay up once raised, so no refill pause exists.
  assign rdreq = !srst && drdy && (dual || !ph);

  // The FIFO answers one cycle after the request.
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_d    <= 1'b0;
      ph_d    <= 1'b0;
      first_q <= 1'b0;
    end else begin
      rd_d    <= rdreq;
      ph_d    <= ph;
      first_q <= first_data;
    end
  end

  // A word leaves after every single read or every second dual read.
  assign emit = rd_d && (!dual || ph_d);

  // ========================================================================
  // Word assembly
  // ========================================================================

  logic [127:0] lo_hold;
  logic         word_dual;

  // Dual mode parks the A/B half until the C/D half arrives.
  always_ff @(posedge mclk) begin
    if (srst) begin
      lo_hold <= '0;
    end else if (rd_d && dual && !ph_d) begin
      lo_hold <= din;
    end
  end

  // Output word register; valid pulses for one cycle per word.
  always_ff @(posedge mclk) begin
    if (srst) begin
      dout      <= '0;
      out_valid <= 1'b0;
      word_dual <= 1'b0;
    end else begin
      out_valid <= emit;
      if (emit) begin
        word_dual <= dual;
        if (dual) begin
          dout <= {din, lo_hold};
        end else begin
          dout <= {din, din};
        end
      end
    end
  end

  // ========================================================================
  // Frame and sync markers
  // ========================================================================

  logic       pat_pend;
  logic [2:0] fcnt;
  logic       frame_hit;

  // The start flag lasts two cycles, so only its rising edge counts; a new
  // start in the emit cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pat_pend <= 1'b0;
    end else if (first_data && !first_q) begin
      pat_pend <= 1'b1;
    end else if (emit) begin
      pat_pend <= 1'b0;
    end
  end

  // A pattern start realigns the frame count to its first word.
  assign frame_hit = pat_pend || (fcnt == 3'h0);

  // Word counter: eight words of eight samples per bus make one frame.
  always_ff @(posedge mclk) begin
    if (srst) begin
      fcnt <= 3'h0;
    end else if (emit) begin
      if (pat_pend) begin
        fcnt <= 3'h1;
      end else if (fcnt == dsf_pkg::FCNT_LAST) begin
        fcnt <= 3'h0;
      end else begin
        fcnt <= fcnt + 3'h1;
      end
    end
  end

  // Marker vectors follow the word they belong to; gates blank them.
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_out <= '0;
      sync_out  <= '0;
    end else if (emit) begin
      frame_out <= (frame_hit && fgate) ? dsf_pkg::MARK_FIRST : '0;
      sync_out  <= (pat_pend && sgate) ? dsf_pkg::MARK_FIRST : '0;
    end
  end

  // ========================================================================
  // Reference clock ratio monitor
  // ========================================================================

  logic [2:0] ref_cnt;

  // Counts core cycles between reference edges; lock means exactly four.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ref_q    <= 1'b0;
      ref_cnt  <= 3'h0;
      ref_lock <= 1'b0;
    end else begin
      ref_q <= ref_s;
      if (ref_s && !ref_q) begin
        ref_lock <= (ref_cnt == dsf_pkg::REF_CNT_LAST);
        ref_cnt  <= 3'h0;
      end else if (ref_cnt != dsf_pkg::REF_CNT_MAX) begin
        ref_cnt <= ref_cnt + 3'h1;
      end
    end
  end

  // ========================================================================
  // Link transmitters
  // ========================================================================

  logic [18:0] ab_out;
  logic        ab_ready;
  logic        cd_ready;
  logic        ser_load;

  // Both paths take the same word, so they never drift a word apart.
  assign ser_load = out_valid && ab_ready && cd_ready;

  // A/B path also carries frame, sync and the forwarded clock.
  lane_serializer #(.LANES(dsf_pkg::AB_LINK_LANES)) u_ab_ser (
    .mclk      (mclk),
    .srst      (srst),
    .par_word  ({dsf_pkg::DCLK_PATTERN, rotate_mark(sync_out),
                 rotate_mark(frame_out), rotate_half(dout[127:0])}),
    .load      (ser_load),
    .ready     (ab_ready),
    .ser_clk   (ser_clk),
    .link_rst  (link_rst),
    .lanes_out (ab_out)
  );

  // C/D path is independent and carries data only.
  lane_serializer #(.LANES(dsf_pkg::LANE_W)) u_cd_ser (
    .mclk      (mclk),
    .srst      (srst),
    .par_word  (rotate_half(dout[255:128])),
    .load      (ser_load),
    .ready     (cd_ready),
    .ser_clk   (ser_clk),
    .link_rst  (link_rst),
    .lanes_out (cd_lane)
  );

  // A single frame and sync line serve even a dual-bus converter.
  assign ab_lane    = ab_out[15:0];
  assign frame_line = ab_out[16];
  assign sync_line  = ab_out[17];
  assign dclk_line  = ab_out[18];

  // ========================================================================
  // Checks
  // ========================================================================

  a_valid_alternate: assert property (@(posedge mclk) disable iff (srst)
    out_valid |=> !out_valid)
    else $error("Output word valid on two adjacent cycles.");

  a_rdreq_dual: assert property (@(posedge mclk) disable iff (srst)
    dual && drdy |-> rdreq)
    else $error("Dual mode missed a read while ready.");

  a_rdreq_single: assert property (@(posedge mclk) disable iff (srst)
    !dual && rdreq |=> !rdreq)
    else $error("Single mode read on adjacent cycles.");

  a_single_mirror: assert property (@(posedge mclk) disable iff (srst)
    out_valid && !word_dual |-> dout[255:128] == dout[127:0])
    else $error("Single mode halves differ.");

  a_dual_halves: assert property (@(posedge mclk) disable iff (srst)
    out_valid && word_dual |-> dout[127:0] == $past(din, 2) && dout[255:128] == $past(din))
    else $error("Dual mode halves out of order.");

  a_sync_mark: assert property (@(posedge mclk) disable iff (srst)
    emit && pat_pend && sgate |=> sync_out == dsf_pkg::MARK_FIRST && out_valid)
    else $error("Pattern start word lacks sync marker.");

  a_frame_mark: assert property (@(posedge mclk) disable iff (srst)
    emit && !pat_pend && fcnt == dsf_pkg::FCNT_LAST ##2 emit |=> frame_out[0] == $past(fgate))
    else $error("Frame marker not every 64 samples.");

  a_gate_zero: assert property (@(posedge mclk) disable iff (srst)
    emit && !fgate && !sgate |=> frame_out == '0 && sync_out == '0)
    else $error("Gated marker not forced to zero.");

  a_reset_clear: assert property (@(posedge mclk)
    srst |=> !ph && fcnt == 3'h0 && frame_out == '0 && sync_out == '0 && !out_valid)
    else $error("Reset left state uncleared.");

endmodule : dac_sample_formatter

`default_nettype wire

// File: src/dsf_pkg.sv
// ==========================================================================
// Shared constants for the sample formatter and its link serializers.
// ==========================================================================
package dsf_pkg;

  // Word widths on the parallel side.
  localparam int HALF_W           = 128;
  localparam int WORD_W           = 256;
  localparam int SAMPLE_W         = 16;
  localparam int MARK_W           = 16;
  localparam int SAMPLES_PER_HALF = HALF_W / SAMPLE_W;

  // Link geometry: every lane is serialized 8:1.
  localparam int LANE_W           = 16;
  localparam int SER_RATIO        = 8;
  localparam int AB_LINK_LANES    = LANE_W + 3;
  localparam logic [2:0] BEAT_LAST = 3'(SER_RATIO - 1);

  // Frame marker spacing in samples on one bus, and in output words.
  localparam int FRAME_SAMPLES    = 64;
  localparam int WORDS_PER_FRAME  = FRAME_SAMPLES / SAMPLES_PER_HALF;
  localparam logic [2:0] FCNT_LAST = 3'(WORDS_PER_FRAME - 1);

  // Converter type code that selects dual-bus formatting.
  localparam logic [1:0] DUAL_SEL = 2'h3;

  // Marker pattern: first sample of each half carries the marker.
  localparam logic [15:0] MARK_FIRST = 16'h0101;

  // Bit pattern sent on the forwarded data clock lane per word.
  localparam logic [7:0] DCLK_PATTERN = 8'hAA;

  // Core clock runs at this multiple of the reference clock.
  localparam int REF_RATIO             = 4;
  localparam logic [2:0] REF_CNT_LAST  = 3'(REF_RATIO - 1);
  localparam logic [2:0] REF_CNT_MAX   = 3'h7;

endpackage : dsf_pkg

// File: src/lane_serializer.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// 8:1 serializer for a group of lanes. A word is captured on the core
// clock and handed to the link clock with a toggle handshake.
// ==========================================================================
module lane_serializer #(
  parameter int LANES = 16
) (
  // Core side.
  input  wire logic                                 mclk,
  input  wire logic                                 srst,
  input  wire logic [dsf_pkg::SER_RATIO*LANES-1:0]  par_word,
  input  wire logic                                 load,
  output logic                                      ready,
  // Link side.
  input  wire logic                                 ser_clk,
  input  wire logic                                 link_rst,
  output logic      [LANES-1:0]                     lanes_out
);

  logic [dsf_pkg::SER_RATIO*LANES-1:0] hold;
  logic [dsf_pkg::SER_RATIO*LANES-1:0] shreg;
  logic                                req_t;
  logic                                req_s;
  logic                                ack_t;
  logic                                ack_s;
  logic [2:0]                          beat;

  bit_sync #(.WIDTH(1)) u_ack_sync (.clk(mclk),    .d(ack_t), .q(ack_s));
  bit_sync #(.WIDTH(1)) u_req_sync (.clk(ser_clk), .d(req_t), .q(req_s));

  // Free again once the link has echoed the last request.
  assign ready = (req_t == ack_s);

  // Parallel-clock holding register; it only changes once the link has taken the previous word.
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold  <= '0;
      req_t <= 1'b0;
    end else if (load && ready) begin
      hold  <= par_word;
      req_t <= ~req_t;
    end
  end

  // Beat counter; its wrap is the slow load phase of the serializer.
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      beat <= 3'h0;
    end else if (beat == dsf_pkg::BEAT_LAST) begin
      beat <= 3'h0;
    end else begin
      beat <= beat + 3'h1;
    end
  end

  // Load a pending word at the word boundary; otherwise repeat the last one.
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      shreg <= '0;
      ack_t <= 1'b0;
    end else if (beat == dsf_pkg::BEAT_LAST && req_s != ack_t) begin
      shreg <= hold;
      ack_t <= req_s;
    end
  end

  // Each lane owns one byte of the word and sends it MSB first.
  for (genvar j = 0; j < LANES; j++) begin : g_lane
    always_ff @(posedge ser_clk) begin
      if (link_rst) begin
        lanes_out[j] <= 1'b0;
      end else begin
        lanes_out[j] <= shreg[j*dsf_pkg::SER_RATIO + int'(dsf_pkg::BEAT_LAST - beat)];
      end
    end
  end

endmodule : lane_serializer

`default_nettype wire

// File: verification/dac_link_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Converter-side receiver for the serial link.
// ==========================================
module dac_link_model (
  // Link from the transmitter.
  input  wire logic         ser_clk,
  input  wire logic [15:0]  ab_lane,
  input  wire logic [15:0]  cd_lane,
  input  wire logic         frame_line,
  input  wire logic         sync_line,
  input  wire logic         dclk_line,
  // Last word that carried a frame mark on its first beat.
  output logic      [127:0] ab_word,
  output logic      [127:0] cd_word,
  output logic      [7:0]   frame_bits,
  output logic      [7:0]   sync_bits,
  output logic      [7:0]   clk_bits,
  output int                words
);
  logic [34:0] hist [8];

  initial words = 0;

  // The frame line is the only word alignment the converter gets, so a
  // word is taken when the beat seven edges back carried the frame mark.
  always @(posedge ser_clk) begin
    for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
    hist[0] = {dclk_line, sync_line, frame_line, cd_lane, ab_lane};
    if (hist[7][32] === 1'b1) begin
      for (int b = 0; b < 8; b++) begin
        ab_word[16*b +: 16] = hist[7-b][15:0];
        cd_word[16*b +: 16] = hist[7-b][31:16];
        frame_bits[b]       = hist[7-b][32];
        sync_bits[b]        = hist[7-b][33];
        clk_bits[7-b]       = hist[7-b][34];
      end
      words = words + 1;
    end
  end
endmodule : dac_link_model

`default_nettype wire

// File: verification/dac_sample_formatter_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Self-checking bench for the sample formatter.
// ==========================================
module dac_sample_formatter_tb;
  logic         mclk = 1'b0, ser_clk = 1'b0, srst = 1'b1, pop = 1'b0;
  logic         drdy = 1'b0, first_data = 1'b0, reference_clock_input = 1'b0;
  logic         frame_en = 1'b1, sync_en = 1'b1;
  logic [1:0]   dac_sel = 2'h3;
  logic [127:0] din = 128'h0, ab_word, cd_word;
  logic         rdreq, out_valid, ref_lock, frame_line, sync_line, dclk_line;
  logic [255:0] dout;
  logic [15:0]  frame_out, sync_out, ab_lane, cd_lane;
  logic [7:0]   frame_bits, sync_bits, clk_bits;
  int           words, fail_count = 0, checks = 0, seq = 0, cyc = 0;
  logic [255:0] wq [$];
  logic [15:0]  fq [$], sq [$];
  logic         rq [$];
  int           vq [$];

  dac_sample_formatter u_dut (.mclk(mclk), .srst(srst), .ser_clk(ser_clk),
    .drdy(drdy), .first_data(first_data), .din(din), .rdreq(rdreq),
    .dac_sel(dac_sel), .frame_en(frame_en), .sync_en(sync_en),
    .reference_clock_input(reference_clock_input), .dout(dout),
    .out_valid(out_valid), .frame_out(frame_out), .sync_out(sync_out),
    .ref_lock(ref_lock), .ab_lane(ab_lane), .cd_lane(cd_lane),
    .frame_line(frame_line), .sync_line(sync_line), .dclk_line(dclk_line));

  dac_link_model u_link (.ser_clk(ser_clk), .ab_lane(ab_lane), .cd_lane(cd_lane),
    .frame_line(frame_line), .sync_line(sync_line), .dclk_line(dclk_line),
    .ab_word(ab_word), .cd_word(cd_word), .frame_bits(frame_bits),
    .sync_bits(sync_bits), .clk_bits(clk_bits), .words(words));

  // Core clock; the link clock starts off phase so the two never line up.
  always #12.5 mclk = ~mclk;
  initial begin
    #7;
    forever #62.5 ser_clk = ~ser_clk;
  end

  // Every sample carries its word number and position, so a swap shows.
  function automatic logic [127:0] make_word(input int s);
    for (int i = 0; i < 8; i++) make_word[16*i +: 16] = {s[11:0], 4'(i)};
  endfunction : make_word

  // Reference clock at a quarter of the core rate; FIFO with one cycle of
  // latency; monitor sampling 5 ns after the fall, once outputs settled.
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (cyc[0]) reference_clock_input <= ~reference_clock_input;
    if (pop) begin
      din <= make_word(seq);
      seq <= seq + 1;
    end
    #5;
    pop = (rdreq === 1'b1);
    if (drdy) rq.push_back(rdreq);
    if (out_valid === 1'b1) begin
      wq.push_back(dout);
      fq.push_back(frame_out);
      sq.push_back(sync_out);
      vq.push_back(cyc);
    end
  end

  task automatic chk_word(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // One pattern: the bridge raises ready and holds the start flag two
  // cycles; ready stays up until twelve words have come out.
  task automatic burst(input logic [1:0] sel);
    @(negedge mclk);
    drdy = 1'b0;
    dac_sel = sel;
    repeat (80) @(negedge mclk);
    seq = 0;
    wq.delete(); fq.delete(); sq.delete(); rq.delete(); vq.delete();
    drdy = 1'b1;
    first_data = 1'b1;
    repeat (2) @(negedge mclk);
    first_data = 1'b0;
    for (int t = 0; t < 200 && wq.size() < 12; t++) @(negedge mclk);
    drdy = 1'b0;
  endtask : burst

  task automatic check_words(input logic dual, input logic fe, input logic se);
    logic [127:0] lo, hi;
    chk_bits(16'(wq.size() >= 12), 16'h0001);
    for (int k = 0; k < 12 && k < wq.size(); k++) begin
      lo = dual ? make_word(2*k) : make_word(k);
      hi = dual ? make_word(2*k+1) : lo;
      chk_word(wq[k], {hi, lo});
      chk_bits(fq[k], (fe && k % 8 == 0) ? 16'h0101 : 16'h0000);
      chk_bits(sq[k], (se && k == 0) ? 16'h0101 : 16'h0000);
      if (k > 0) chk_bits(16'(vq[k] - vq[k-1]), 16'h0002);
    end
    for (int i = 0; i < rq.size(); i++)
      chk_bits(16'(rq[i]), dual ? 16'h0001 : 16'(~i & 1));
  endtask : check_words

  task automatic test_dual;
    burst(2'h3);
    check_words(1'b1, 1'b1, 1'b1);
    $display("test_dual done");
  endtask : test_dual

  task automatic test_single_codes;
    for (int c = 0; c < 3; c++) begin
      burst(2'(c));
      check_words(1'b0, 1'b1, 1'b1);
    end
    $display("test_single_codes done");
  endtask : test_single_codes

  task automatic test_gates;
    frame_en = 1'b0;
    burst(2'h3);
    check_words(1'b1, 1'b0, 1'b1);
    frame_en = 1'b1;
    sync_en = 1'b0;
    burst(2'h1);
    check_words(1'b0, 1'b1, 1'b0);
    sync_en = 1'b1;
    $display("test_gates done");
  endtask : test_gates

  // Reset in mid-stream; long enough to reach the link domain as well.
  task automatic test_reset;
    @(negedge mclk);
    dac_sel = 2'h3;
    drdy = 1'b1;
    repeat (5) @(negedge mclk);
    srst = 1'b1;
    repeat (24) @(negedge mclk);
    chk_bits({13'h0, ref_lock, rdreq, out_valid}, 16'h0000);
    chk_bits(frame_out | sync_out, 16'h0000);
    chk_word(dout, 256'h0);
    srst = 1'b0;
    drdy = 1'b0;
    @(negedge mclk);
    #5;
    chk_bits(16'(rdreq), 16'h0000);
    $display("test_reset done");
  endtask : test_reset

  // A single dual-bus word, then the bridge is flushed; the link keeps
  // repeating it, and the receiver must see it in lane order.
  task automatic test_link;
    int w0;
    repeat (80) @(negedge mclk);
    w0 = words;
    seq = 0;
    drdy = 1'b1;
    first_data = 1'b1;
    repeat (2) @(negedge mclk);
    drdy = 1'b0;
    first_data = 1'b0;
    for (int t = 0; t < 400 && words < w0 + 2; t++) @(negedge mclk);
    chk_word({ab_word, cd_word}, {make_word(0), make_word(1)});
    chk_bits({frame_bits, sync_bits}, 16'h0101);
    chk_bits({8'h00, clk_bits}, 16'h00AA);
    chk_bits(16'(ref_lock), 16'h0001);
    $display("test_link done");
  endtask : test_link

  // Watchdog sized well beyond the few tens of microseconds the run needs.
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (24) @(negedge mclk);
    srst = 1'b0;
    test_dual();
    test_single_codes();
    test_gates();
    test_reset();
    test_link();
    give_verdict();
  end
endmodule : dac_sample_formatter_tb

`default_nettype wire
